// ### rtl/vic_core.sv
// Purpose: pending latches, enables, priority, acceptance and return sequences
// Assumes: strobes and requests are synchronous single-cycle pulses
// Notes:   all outputs are registered; sequences stall the core via seq_busy_r
`timescale 1ns/1ps

// How it works
// - a source request sets its pending latch, which asks for service
// - acceptance clears the taken latch; reset clears every latch
// - latches read at 3c/3d and cleared by plain byte writes
// - no register write can ever set a pending latch
// - enable register at 3a/3b, readable and writable except bits 3..1, which read zero
// - master enable is bit 0, resets low, set by ei, cleared by di
// - master enable low blocks every maskable source
// - software and watchdog ignore enables, one of them in service at once
// - enable bits 4..15 gate their own sources
// - external 0 gated by master enable only; its latch needs the pin function on
// - a pending latch holds until accepted, reset or cleared
// - acceptance runs twelve cycles after the instruction, clearing master enable first
// - push status high, status low, pc ext, pc high, pc low
// - load pc from vector, add low nibble of bank code to bank selector
// - maskable return sets master enable, pending work taken at once
// - non-maskable return restores master enable only if it was set and kept
// - both returns restore the previous register bank
// - lowest source number wins among eligible requests
// - returns pop five bytes, stack pointer up five times
// - requests sampled in the last cycle of each instruction
module vic_core #(
  parameter int BANK_DEPTH = vic_pkg::BANK_DEPTH
) (
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire logic [15:0]          irq_req,
  input  wire logic                 ext0_function_enable,
  input  wire vic_pkg::vic_instr_t  instr,
  input  wire logic [7:0]           sfr_addr,
  input  wire logic                 sfr_wr,
  input  wire logic                 sfr_rd,
  input  wire logic [7:0]           sfr_wdata,
  input  wire logic [15:0]          cur_psw,
  input  wire logic [19:0]          cur_pc,
  input  wire logic [3:0]           cur_bank,
  input  wire logic [7:0]           vec_rdata,
  output logic      [7:0]           sfr_rdata_r,
  output logic                      seq_busy_r,
  output logic                      accept_r,
  output logic      [3:0]           accept_src_r,
  output vic_pkg::vic_byte_t        push_r,
  output logic                      pop_r,
  output logic                      vec_rd_r,
  output logic      [19:0]          vec_addr_r,
  output logic                      pc_load_r,
  output logic      [19:0]          pc_val_r,
  output logic                      bank_load_r,
  output logic      [3:0]           bank_val_r,
  output logic                      master_enable_flag_r
);

  // ****************************************************************
  // state
  // ****************************************************************
  vic_pkg::vic_state_t state_r;
  vic_pkg::vic_state_t state_nxt;
  logic [3:0]          step_r;
  logic [15:0]         pending_latch_r;
  logic [15:0]         pending_nxt;
  logic [15:0]         source_enable_flag_r;
  logic                nmi_busy_r;
  logic                nmi_imf_r;
  logic                nmi_sw_clr_r;
  logic                is_nmi_ret_r;
  logic                ret_done_r;
  logic [3:0]          src_r;
  logic [23:0]         vec_buf_r;
  logic [7:0]          vec_code_r;
  logic [3:0]          bank_pop;

  // ****************************************************************
  // register decode
  // ****************************************************************
  wire wr_en_lo   = sfr_wr && (sfr_addr == vic_pkg::ADDR_EN_LO);
  wire wr_en_hi   = sfr_wr && (sfr_addr == vic_pkg::ADDR_EN_HI);
  wire wr_pend_lo = sfr_wr && (sfr_addr == vic_pkg::ADDR_PEND_LO);
  wire wr_pend_hi = sfr_wr && (sfr_addr == vic_pkg::ADDR_PEND_HI);

  wire [15:0] en_view = {source_enable_flag_r[15:1], master_enable_flag_r}
                        & vic_pkg::EN_MASK;
  wire [7:0]  rd_mux  = (sfr_addr == vic_pkg::ADDR_EN_LO)   ? en_view[7:0] :
                        (sfr_addr == vic_pkg::ADDR_EN_HI)   ? en_view[15:8] :
                        (sfr_addr == vic_pkg::ADDR_PEND_LO) ? pending_latch_r[7:0] :
                        (sfr_addr == vic_pkg::ADDR_PEND_HI) ? pending_latch_r[15:8] :
                        8'h00;

  // written zero clears, written one keeps; nothing here can set
  wire [15:0] wr_keep = {wr_pend_hi ? sfr_wdata : 8'hff,
                         wr_pend_lo ? sfr_wdata : 8'hff};

  // ****************************************************************
  // request conditioning and eligibility
  // ****************************************************************
  wire [15:0] req_gated = {irq_req[15:4],
                           irq_req[3] & ext0_function_enable,
                           irq_req[2:0]} & vic_pkg::PEND_MASK;

  wire [15:0] eligible;
  assign eligible[1:0]  = 2'b00;
  assign eligible[2]    = pending_latch_r[2] & ~nmi_busy_r;
  assign eligible[3]    = pending_latch_r[3] & master_enable_flag_r;
  assign eligible[15:4] = pending_latch_r[15:4] & source_enable_flag_r[15:4]
                          & {12{master_enable_flag_r}};

  logic [3:0] pick;
  logic       pick_any;
  always_comb begin
    pick     = 4'h0;
    pick_any = 1'b0;
    for (int i = vic_pkg::NUM_SRC - 1; i >= vic_pkg::SRC_WDT; i--) begin
      if (eligible[i]) begin
        pick     = 4'(i);
        pick_any = 1'b1;
      end
    end
  end

  // requests are looked at on an instruction's last cycle or right after a return
  wire sample   = (state_r == vic_pkg::VIC_IDLE) &&
                  (instr.last_cycle || ret_done_r);
  wire take_swi = sample && instr.software_trap_instr && !nmi_busy_r;
  wire take_hw  = sample && !take_swi && pick_any;
  wire take     = take_swi || take_hw;
  wire [3:0] take_src = take_swi ? 4'(vic_pkg::SRC_SWI) : pick;
  wire take_nmi = take_swi || (take_hw && pick == 4'(vic_pkg::SRC_WDT));
  wire start_ret = (state_r == vic_pkg::VIC_IDLE) && !take &&
                   (instr.maskable_return_instr || instr.nonmaskable_return_instr);
  wire ret_last  = (state_r == vic_pkg::VIC_RETURN) &&
                   (step_r == vic_pkg::POP_BYTES - 4'h1);
  wire acc_last  = (state_r == vic_pkg::VIC_ACCEPT) &&
                   (step_r == vic_pkg::ACC_CYCLES - 4'h1);

  // ****************************************************************
  // pending latches
  // ****************************************************************
  wire [15:0] acc_clr = take_hw ? (16'h0001 << pick) : 16'h0000;
  assign pending_nxt = (pending_latch_r & wr_keep & ~acc_clr)
                       | req_gated;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pending_latch_r <= vic_pkg::PEND_RST;
    end else begin
      pending_latch_r <= pending_nxt;
    end
  end

  // ****************************************************************
  // enable register and master enable
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      source_enable_flag_r <= vic_pkg::EN_RST;
    end else begin
      if (wr_en_lo) begin
        source_enable_flag_r[7:0] <= sfr_wdata & vic_pkg::EN_MASK[7:0];
      end
      if (wr_en_hi) begin
        source_enable_flag_r[15:8] <= sfr_wdata;
      end
    end
  end

  wire imf_sw_clear = instr.di || (wr_en_lo && !sfr_wdata[vic_pkg::IMF_BIT]);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      master_enable_flag_r <= vic_pkg::EN_RST[vic_pkg::IMF_BIT];
    end else if (take) begin
      master_enable_flag_r <= 1'b0;
    end else if (ret_last) begin
      master_enable_flag_r <= is_nmi_ret_r ? (nmi_imf_r & ~nmi_sw_clr_r)
                                           : 1'b1;
    end else if (instr.ei) begin
      master_enable_flag_r <= 1'b1;
    end else if (imf_sw_clear) begin
      master_enable_flag_r <= 1'b0;
    end else if (wr_en_lo) begin
      master_enable_flag_r <= sfr_wdata[vic_pkg::IMF_BIT];
    end
  end

  // ****************************************************************
  // pseudo non-maskable bookkeeping
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      nmi_busy_r   <= 1'b0;
      nmi_imf_r    <= 1'b0;
      nmi_sw_clr_r <= 1'b0;
    end else if (take_nmi) begin
      nmi_busy_r   <= 1'b1;
      nmi_imf_r    <= master_enable_flag_r;
      nmi_sw_clr_r <= 1'b0;
    end else if (ret_last && is_nmi_ret_r) begin
      nmi_busy_r <= 1'b0;
    end else if (nmi_busy_r && imf_sw_clear) begin
      nmi_sw_clr_r <= 1'b1;
    end
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_comb begin
    case (state_r)
      vic_pkg::VIC_IDLE: begin
        if (take) begin
          state_nxt = vic_pkg::VIC_ACCEPT;
        end else if (start_ret) begin
          state_nxt = vic_pkg::VIC_RETURN;
        end else begin
          state_nxt = vic_pkg::VIC_IDLE;
        end
      end
      vic_pkg::VIC_ACCEPT: begin
        state_nxt = acc_last ? vic_pkg::VIC_IDLE : vic_pkg::VIC_ACCEPT;
      end
      vic_pkg::VIC_RETURN: begin
        state_nxt = ret_last ? vic_pkg::VIC_IDLE : vic_pkg::VIC_RETURN;
      end
      default: begin
        state_nxt = vic_pkg::VIC_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r      <= vic_pkg::VIC_IDLE;
      step_r       <= 4'h0;
      src_r        <= 4'h0;
      is_nmi_ret_r <= 1'b0;
      ret_done_r   <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      step_r     <= (state_nxt == state_r) ? step_r + 4'h1 : 4'h0;
      ret_done_r <= ret_last;
      if (take) begin
        src_r <= take_src;
      end
      if (start_ret) begin
        is_nmi_ret_r <= instr.nonmaskable_return_instr;
      end
    end
  end

  // ****************************************************************
  // acceptance data path
  // ****************************************************************
  wire in_acc  = (state_r == vic_pkg::VIC_ACCEPT);
  wire in_push = in_acc && (step_r < vic_pkg::PUSH_BYTES);
  wire in_vec  = in_acc && (step_r >= vic_pkg::PUSH_BYTES) &&
                 (step_r < vic_pkg::PUSH_BYTES + vic_pkg::VEC_BYTES);
  wire in_cap  = in_acc && (step_r >= vic_pkg::PUSH_BYTES + vic_pkg::VEC_LAG) &&
                 (step_r < vic_pkg::PUSH_BYTES + vic_pkg::VEC_LAG + vic_pkg::VEC_BYTES);
  wire [3:0] vec_idx = step_r - vic_pkg::PUSH_BYTES;
  wire [3:0] cap_idx = step_r - vic_pkg::PUSH_BYTES - vic_pkg::VEC_LAG;
  wire [19:0] vec_base = vic_pkg::VEC_TOP - {14'h0000, src_r, 2'b00};

  logic [7:0] push_byte;
  always_comb begin
    case (step_r)
      4'h0:    push_byte = cur_psw[15:8];
      4'h1:    push_byte = cur_psw[7:0];
      4'h2:    push_byte = {4'h0, cur_pc[19:16]};
      4'h3:    push_byte = cur_pc[15:8];
      4'h4:    push_byte = cur_pc[7:0];
      default: push_byte = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      vec_buf_r  <= 24'h000000;
      vec_code_r <= 8'h00;
    end else if (in_cap) begin
      case (cap_idx)
        4'h0:    vec_buf_r[7:0]   <= vec_rdata;
        4'h1:    vec_buf_r[15:8]  <= vec_rdata;
        4'h2:    vec_buf_r[23:16] <= vec_rdata;
        default: vec_code_r       <= vec_rdata;
      endcase
    end
  end

  // ****************************************************************
  // bank save and restore
  // ****************************************************************
  vic_bank_stack #(
    .DEPTH (BANK_DEPTH),
    .WIDTH (4)
  ) u_bank_stack (
    .core_clk (core_clk),
    .rst      (rst),
    .push     (acc_last),
    .pop      (start_ret),
    .wdata    (cur_bank),
    .rdata_r  (bank_pop)
  );

  // ****************************************************************
  // registered outputs
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sfr_rdata_r  <= 8'h00;
      seq_busy_r   <= 1'b0;
      accept_r     <= 1'b0;
      accept_src_r <= 4'h0;
      push_r       <= '0;
      pop_r        <= 1'b0;
      vec_rd_r     <= 1'b0;
      vec_addr_r   <= 20'h00000;
      pc_load_r    <= 1'b0;
      pc_val_r     <= 20'h00000;
      bank_load_r  <= 1'b0;
      bank_val_r   <= 4'h0;
    end else begin
      if (sfr_rd) begin
        sfr_rdata_r <= rd_mux;
      end
      seq_busy_r   <= (state_nxt != vic_pkg::VIC_IDLE);
      accept_r     <= take;
      if (take) begin
        accept_src_r <= take_src;
      end
      push_r.en    <= in_push;
      push_r.data  <= in_push ? push_byte : 8'h00;
      pop_r        <= (state_r == vic_pkg::VIC_RETURN);
      vec_rd_r     <= in_vec;
      vec_addr_r   <= in_vec ? vec_base + {16'h0000, vec_idx} : 20'h00000;
      pc_load_r    <= acc_last;
      pc_val_r     <= acc_last ? vec_buf_r[19:0] : pc_val_r;
      bank_load_r  <= acc_last || ret_last;
      if (acc_last) begin
        bank_val_r <= cur_bank + vec_code_r[3:0];
      end else if (ret_last) begin
        bank_val_r <= bank_pop;
      end
    end
  end

endmodule

// ### rtl/vic_pkg.sv
// Purpose: shared constants and types for the vectored interrupt controller
// Assumes: one byte wide special function register port, 20-bit program space
// Notes:   sources 2..15 own a pending latch, source 1 is the software trap
package vic_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] ADDR_EN_LO   = 8'h3a;
  localparam logic [7:0] ADDR_EN_HI   = 8'h3b;
  localparam logic [7:0] ADDR_PEND_LO = 8'h3c;
  localparam logic [7:0] ADDR_PEND_HI = 8'h3d;

  // ****************************************************************
  // field layout and reset values
  // ****************************************************************
  localparam int          NUM_SRC      = 16;
  localparam int          IMF_BIT      = 0;
  localparam int          SRC_SWI      = 1;
  localparam int          SRC_WDT      = 2;
  localparam int          SRC_EXT0     = 3;
  localparam int          FIRST_EF     = 4;
  localparam logic [15:0] PEND_MASK    = 16'hfffc;
  localparam logic [15:0] EN_MASK      = 16'hfff1;
  localparam logic [15:0] PEND_RST     = 16'h0000;
  localparam logic [15:0] EN_RST       = 16'h0000;

  // ****************************************************************
  // sequence timing and vectors
  // ****************************************************************
  localparam logic [3:0]  ACC_CYCLES   = 4'hc;
  localparam logic [3:0]  PUSH_BYTES   = 4'h5;
  localparam logic [3:0]  VEC_BYTES    = 4'h4;
  localparam logic [3:0]  VEC_LAG      = 4'h2;
  localparam logic [3:0]  POP_BYTES    = 4'h5;
  localparam logic [19:0] VEC_TOP      = 20'hffffc;
  localparam int          BANK_DEPTH   = 16;

  typedef enum logic [1:0] {
    VIC_IDLE   = 2'b00,
    VIC_ACCEPT = 2'b01,
    VIC_RETURN = 2'b10
  } vic_state_t;

  // instruction strobes from the core sequencer
  typedef struct packed {
    logic last_cycle;
    logic ei;
    logic di;
    logic maskable_return_instr;
    logic nonmaskable_return_instr;
    logic software_trap_instr;
  } vic_instr_t;

  // one byte moved to or from the stack
  typedef struct packed {
    logic       en;
    logic [7:0] data;
  } vic_byte_t;

endpackage

// ### rtl/vic_bank_stack.sv
// Purpose: small lifo holding the register bank in use before each acceptance
// Assumes: push and pop never in the same cycle
// Notes:   read data is the popped entry, held in a register
`timescale 1ns/1ps
module vic_bank_stack #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 4
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             push,
  input  wire logic             pop,
  input  wire logic [WIDTH-1:0] wdata,
  output logic      [WIDTH-1:0] rdata_r
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    ptr_r;
  logic [PW-1:0]    ptr_dn;

  assign ptr_dn = ptr_r - 1'b1;

  // ****************************************************************
  // pointer and storage
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ptr_r   <= '0;
      rdata_r <= '0;
    end else if (push) begin
      ptr_r <= ptr_r + 1'b1;
    end else if (pop) begin
      ptr_r   <= ptr_dn;
      rdata_r <= mem[ptr_dn];
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[ptr_r] <= wdata;
    end
  end

endmodule

// ### test/vic_core_props.sv
// Purpose: concurrent checks on the interrupt controller ports
// Assumes: outputs registered, walk timing as handed over
// Notes:   bound to vic_core at the foot of this file
`timescale 1ns/1ps
module vic_core_props #(
  parameter int BANK_DEPTH = vic_pkg::BANK_DEPTH
) (
  input wire logic                core_clk,
  input wire logic                rst,
  input wire vic_pkg::vic_instr_t instr,
  input wire logic [7:0]          sfr_addr,
  input wire logic                sfr_rd,
  input wire logic [7:0]          sfr_rdata_r,
  input wire logic                seq_busy_r,
  input wire logic                accept_r,
  input wire vic_pkg::vic_byte_t  push_r,
  input wire logic                pop_r,
  input wire logic                vec_rd_r,
  input wire logic [19:0]         vec_addr_r,
  input wire logic                pc_load_r,
  input wire logic                bank_load_r,
  input wire logic                master_enable_flag_r
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // ****
  // sequences and properties
  // ****
  sequence s_push5;
    push_r.en [*5] ##1 !push_r.en;
  endsequence
  sequence s_vec4;
    vec_rd_r [*4] ##1 !vec_rd_r;
  endsequence
  property p_busy_len;
    accept_r |-> seq_busy_r [*8] ##1 seq_busy_r [*4] ##1 !seq_busy_r;
  endproperty
  property p_imf_clr;
    accept_r |-> !master_enable_flag_r;
  endproperty
  property p_push;
    accept_r |=> s_push5;
  endproperty
  property p_vec;
    accept_r |-> ##6 s_vec4;
  endproperty
  property p_vec_step;
    vec_rd_r && $past(vec_rd_r) |-> vec_addr_r == $past(vec_addr_r) + 20'h1;
  endproperty
  property p_load;
    accept_r |-> ##12 (pc_load_r && bank_load_r);
  endproperty
  property p_mret;
    instr.maskable_return_instr && instr.last_cycle && !seq_busy_r
      |-> ##2 pop_r [*4] ##1 (pop_r && master_enable_flag_r);
  endproperty
  property p_nret;
    instr.nonmaskable_return_instr && instr.last_cycle && !seq_busy_r |-> ##2 pop_r [*5] ##1 !pop_r;
  endproperty
  property p_dis;
    instr.di |=> !master_enable_flag_r;
  endproperty
  property p_en;
    instr.ei && !instr.di && !instr.last_cycle && !seq_busy_r |=> master_enable_flag_r;
  endproperty
  property p_pend_rd;
    sfr_rd && sfr_addr == vic_pkg::ADDR_PEND_LO |=> sfr_rdata_r[1:0] == 2'h0;
  endproperty
  property p_en_rd;
    sfr_rd && sfr_addr == vic_pkg::ADDR_EN_LO |=> sfr_rdata_r[3:1] == 3'h0;
  endproperty
  property p_rst;
    disable iff (1'b0) rst |=> !master_enable_flag_r && !seq_busy_r && !accept_r;
  endproperty
  a_busy_len:
    assert property (p_busy_len) else $error("busy length wrong");
  a_imf_clr:
    assert property (p_imf_clr) else $error("master enable kept on accept");
  a_push:
    assert property (p_push) else $error("push count wrong");
  a_vec:
    assert property (p_vec) else $error("vector reads wrong");
  a_vec_step:
    assert property (p_vec_step) else $error("vector address step wrong");
  a_load:
    assert property (p_load) else $error("pc or bank load late");
  a_mret:
    assert property (p_mret) else $error("maskable return wrong");
  a_nret:
    assert property (p_nret) else $error("pop count wrong");
  a_dis:
    assert property (p_dis) else $error("disable strobe ignored");
  a_en:
    assert property (p_en) else $error("enable strobe ignored");
  a_pend_rd:
    assert property (p_pend_rd) else $error("pending bits 1:0 not zero");
  a_en_rd:
    assert property (p_en_rd) else $error("enable bits 3:1 not zero");
  a_rst:
    assert property (p_rst) else $error("reset state wrong");
endmodule
bind vic_core vic_core_props #(.BANK_DEPTH(BANK_DEPTH)) i_props (
  .core_clk, .rst, .instr, .sfr_addr, .sfr_rd, .sfr_rdata_r, .seq_busy_r, .accept_r,
  .push_r, .pop_r, .vec_rd_r, .vec_addr_r, .pc_load_r, .bank_load_r,
  .master_enable_flag_r
);

// ### test/vic_core_model.sv
// Purpose: core side stand-in: vector memory and stack log
// Assumes: vector byte answered the cycle after a read request
// Notes:   idle vector data toggles every cycle
`timescale 1ns/1ps
module vic_core_model (
  input  wire logic               core_clk,
  input  wire logic               rst,
  input  wire logic               vec_rd_r,
  input  wire logic [19:0]        vec_addr_r,
  input  wire vic_pkg::vic_byte_t push_r,
  input  wire logic               pop_r,
  output logic      [7:0]         vec_rdata,
  output logic      [39:0]        push_log,
  output logic      [7:0]         pop_cnt
);
  always_ff @(posedge core_clk) begin
    vec_rdata <= vec_rd_r ? vec_addr_r[7:0] : ~vec_rdata;
    if (rst) begin
      vec_rdata <= 8'h5a;
      push_log  <= 40'h0;
      pop_cnt   <= 8'h00;
    end else begin
      if (push_r.en) push_log <= {push_log[31:0], push_r.data};
      if (pop_r) pop_cnt <= pop_cnt + 8'h01;
    end
  end
endmodule

// ### test/test_vectored_interrupt_controller.sv
// Purpose: self-checking bench for vic_core
// Assumes: core side answered by vic_core_model
// Notes:   directed sequences only
`timescale 1ns/1ps
module test_vectored_interrupt_controller;
  localparam logic [5:0] S_LAST = 6'h20, S_EN = 6'h10, S_DIS = 6'h08;
  localparam logic [5:0] S_MRET = 6'h24, S_NRET = 6'h22, S_TRAP = 6'h21;
  logic                core_clk, rst, ext0_function_enable, sfr_wr, sfr_rd;
  logic                seq_busy_r, accept_r, pop_r, vec_rd_r, pc_load_r, bank_load_r;
  logic                master_enable_flag_r;
  logic [15:0]         irq_req, cur_psw;
  logic [19:0]         cur_pc, vec_addr_r, pc_val_r;
  logic [7:0]          sfr_addr, sfr_wdata, vec_rdata, sfr_rdata_r, pop_cnt;
  logic [3:0]          cur_bank, accept_src_r, bank_val_r;
  logic [39:0]         push_log;
  vic_pkg::vic_instr_t instr;
  vic_pkg::vic_byte_t  push_r;
  int                  n_mismatch, total_checks;

  vic_core i_dut (
    .core_clk, .rst, .irq_req, .ext0_function_enable, .instr, .sfr_addr, .sfr_wr,
    .sfr_rd, .sfr_wdata, .cur_psw, .cur_pc, .cur_bank, .vec_rdata, .sfr_rdata_r,
    .seq_busy_r, .accept_r, .accept_src_r, .push_r, .pop_r, .vec_rd_r, .vec_addr_r,
    .pc_load_r, .pc_val_r, .bank_load_r, .bank_val_r, .master_enable_flag_r
  );
  vic_core_model i_model (
    .core_clk, .rst, .vec_rd_r, .vec_addr_r, .push_r, .pop_r, .vec_rdata, .push_log,
    .pop_cnt
  );

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // ****
  // tasks
  // ****
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic await(input int sel);
    int i;
    for (i = 0; i < 40; i++) begin
      if (sel == 0 && accept_r === 1'b1) break;
      if (sel == 1 && pc_load_r === 1'b1) break;
      if (sel == 2 && bank_load_r === 1'b1) break;
      @(posedge core_clk);
      #1;
    end
    if (i == 40) begin
      n_mismatch++;
      $display("wrong value t=%0t timeout", $time);
      close_out();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge core_clk);
    sfr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge core_clk);
    sfr_rd <= 1'b0;
    #1;
    chk(sfr_rdata_r, exp);
  endtask
  task automatic irq(input logic [15:0] v);
    @(posedge core_clk);
    irq_req <= v;
    @(posedge core_clk);
    irq_req <= 16'h0000;
  endtask
  task automatic ins(input logic [5:0] v);
    @(posedge core_clk);
    instr <= v;
    @(posedge core_clk);
    instr <= 6'h00;
    #1;
  endtask
  task automatic taken(input logic [3:0] s, input logic [3:0] bk);
    logic [7:0] b;
    b = 8'hfc - {2'h0, s, 2'h0};
    await(0);
    chk(accept_src_r, s);
    chk(master_enable_flag_r, 0);
    repeat (6) @(posedge core_clk);
    #1;
    chk(vec_addr_r, {12'hfff, b});
    await(1);
    chk(pc_val_r, {b[3:0] + 4'h2, b + 8'h01, b});
    chk(bank_val_r, {bk + b[3:0] + 4'h3});
    chk(push_log, {cur_psw, 4'h0, cur_pc});
    @(posedge core_clk);
    cur_bank <= bank_val_r;
  endtask
  task automatic ret(input logic [5:0] v, input logic master_enable_flag, input logic [3:0] bk);
    logic [7:0] p;
    p = pop_cnt;
    ins(v);
    await(2);
    chk(bank_val_r, bk);
    chk(master_enable_flag_r, master_enable_flag);
    @(posedge core_clk);
    cur_bank <= bank_val_r;
    #1;
    chk(pop_cnt, p + 8'h05);
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    int a;
    rst = 1'b1;
    irq_req = 16'h0000;
    ext0_function_enable = 1'b0;
    instr = 6'h00;
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
    cur_psw = 16'ha5c3;
    cur_pc = 20'h4b2d1;
    cur_bank = 4'h2;
    n_mismatch = 0;
    total_checks = 0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    for (a = 0; a < 4; a++) rd(8'h3a + 8'(a), 8'h00);
    rd(8'h50, 8'h00);
    wr(8'h3a, 8'hff);
    rd(8'h3a, 8'hf1);
    wr(8'h3b, 8'ha5);
    rd(8'h3b, 8'ha5);
    ins(S_DIS);
    chk(master_enable_flag_r, 0);
    ins(S_EN);
    chk(master_enable_flag_r, 1);
    wr(8'h3b, 8'h00);
    wr(8'h3a, 8'h30);
    irq(16'h003b);
    ins(S_LAST);
    rd(8'h3c, 8'h30);
    chk(seq_busy_r, 0);
    wr(8'h3c, 8'hff);
    rd(8'h3c, 8'h30);
    @(posedge core_clk);
    ext0_function_enable <= 1'b1;
    irq(16'h0008);
    rd(8'h3c, 8'h38);
    wr(8'h3c, 8'hf7);
    rd(8'h3c, 8'h30);
    ins(S_EN);
    ins(S_LAST);
    taken(4'h4, 4'h2);
    ins(S_LAST);
    rd(8'h3c, 8'h20);
    chk(seq_busy_r, 0);
    ret(S_MRET, 1'b1, 4'h2);
    taken(4'h5, 4'h2);
    ret(S_MRET, 1'b1, 4'h2);
    ins(S_DIS);
    ins(S_TRAP);
    taken(4'h1, 4'h2);
    irq(16'h0004);
    ins(S_LAST);
    rd(8'h3c, 8'h04);
    chk(seq_busy_r, 0);
    ret(S_NRET, 1'b0, 4'h2);
    taken(4'h2, 4'h2);
    ret(S_NRET, 1'b0, 4'h2);
    ins(S_EN);
    ins(S_TRAP);
    taken(4'h1, 4'h2);
    ret(S_NRET, 1'b1, 4'h2);
    ins(S_EN);
    ins(S_TRAP);
    taken(4'h1, 4'h2);
    ins(S_DIS);
    ret(S_NRET, 1'b0, 4'h2);
    close_out();
  end
endmodule
